// File: hub_cfg_pkg.sv
`default_nettype none
// ==========================================================================
// Shared constants and carriers of the configuration loader
package hub_cfg_pkg;
	// ======================================================================
	// Image layout
	localparam logic [7:0] FMT_EXT      = 8'hD4;
	localparam logic [7:0] FMT_BLANK    = 8'hFF;
	localparam int         IMG_BYTES    = 24;
	localparam int         OFS_VID_LO   = 1;
	localparam int         OFS_VID_HI   = 2;
	localparam int         OFS_PID_LO   = 3;
	localparam int         OFS_PID_HI   = 4;
	localparam int         OFS_DID_HI   = 6;
	localparam int         OFS_OC       = 7;
	localparam int         OFS_MP_FS    = 8;
	localparam int         OFS_MP_HS    = 9;
	localparam int         OFS_HC_FS_BP = 12;
	localparam int         OFS_HC_HS_BP = 13;
	localparam int         OFS_HC_FS_SP = 14;
	localparam int         OFS_HC_HS_SP = 15;
	localparam int         OFS_PWR_ON   = 16;
	localparam int         OFS_LANGS    = 20;
	localparam int         OFS_LANG_ARR = 24;
	localparam int         OC_EN_POS    = 4;
	localparam int         OC_DIS_POS   = 0;
	// ======================================================================
	// Default image values
	localparam logic [7:0] DEF_OC       = 8'h88;
	localparam logic [7:0] DEF_MP_FS    = 8'h28;
	localparam logic [7:0] DEF_MP_HS    = 8'h57;
	localparam logic [7:0] DEF_HC_FS    = 8'h50;
	localparam logic [7:0] DEF_HC_HS_BP = 8'hAE;
	localparam logic [7:0] DEF_HC_HS_SP = 8'h64;
	localparam logic [7:0] DEF_PWR_ON   = 8'h32;
	// Identity defaults: value is arbitrary
	localparam logic [7:0] DEF_ID       = 8'h00;
	// ======================================================================
	// Serial memory commands
	localparam logic [7:0] CMD_READ     = 8'h03;
	localparam int         CMD_A8_POS   = 3;
	localparam logic [8:0] START_ADDR   = 9'h000;
	// ======================================================================
	// Timing
	localparam int         CLK_PERIOD_NS = 20;
	localparam int         SCK_PERIOD_NS = 1000;
	localparam int         SCK_HALF_CYC  = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
	                                       / (2 * CLK_PERIOD_NS);
	// ======================================================================
	// Register offsets
	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_CTRL     = 8'h04;
	localparam logic [7:0] REG_ID       = 8'h08;
	localparam logic [7:0] REG_DEV      = 8'h0C;
	localparam logic [7:0] REG_POWER    = 8'h10;
	localparam logic [7:0] REG_TABLE    = 8'h14;
	localparam int         CTRL_TWO_POS = 0;
	localparam int         CTRL_RLD_POS = 1;
	// ======================================================================
	// Carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} spi_out_s;
	typedef struct packed {
		logic        hub_ready;
		logic        vendor_class;
		logic [15:0] vendor_id;
		logic [15:0] product_id;
		logic [7:0]  device_id_hi;
		logic [3:0]  enabled_port_oc_filter_ms;
		logic [3:0]  disabled_port_oc_filter_ms;
		logic [7:0]  upstream_current_demand;
		logic [7:0]  controller_current_draw;
		logic [7:0]  power_good_delay;
	} cfg_s;
	typedef logic [IMG_BYTES-1:0][7:0] img_t;
	localparam img_t IMG_DEFAULT = {
		{7{8'h00}}, DEF_PWR_ON, DEF_HC_HS_SP, DEF_HC_FS, DEF_HC_HS_BP, DEF_HC_FS,
		8'h00, 8'h00, DEF_MP_HS, DEF_MP_FS, DEF_OC, DEF_ID, 8'h00,
		DEF_ID, DEF_ID, DEF_ID, DEF_ID, 8'h00};
endpackage : hub_cfg_pkg
`default_nettype wire

// File: hub_eeprom_extended_config_load.sv
`default_nettype none
// Operation
// RULE1: byte 0 D4 selects extended layout
// RULE2: identifiers from bytes 1-4 and 6
// RULE3: byte 7 nibbles give overcurrent filter times
// RULE4: byte 8 is full-speed current demand
// RULE5: byte 9 is high-speed current demand
// RULE6: bytes 10 and 11 programmed zero
// RULE7: bus-powered controller current, bytes 12/13
// RULE8: self-powered controller current, bytes 14/15
// RULE9: byte 16 is power-good delay
// RULE10: language array at 24, pointer arrays follow
// RULE11: blank memory gives vendor-class enumeration
// RULE12: two-byte or A8-in-instruction addressing
// RULE13: load finishes before hub answers
module hub_eeprom_extended_config_load #(
	parameter logic ADDR_TWO_BYTE = 1'b1
) (
	// Clock, reset, enable
	input  wire logic                 core_clk,
	input  wire logic                 rstn,
	input  wire logic                 ce,
	// Register bus
	input  wire hub_cfg_pkg::apb_req_s apb_req,
	output var  hub_cfg_pkg::apb_rsp_s apb_rsp,
	// Serial memory
	output var  hub_cfg_pkg::spi_out_s spi_out,
	input  wire logic                 spi_miso,
	// Operating conditions
	input  wire logic                 high_speed,
	input  wire logic                 self_powered,
	// Loaded descriptor values
	output var  hub_cfg_pkg::cfg_s     cfg
);
	// ======================================================================
	// State
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_XFER, ST_FINISH} ld_e;
	typedef struct packed {
		ld_e                   st;       // Loader phase
		logic [7:0]            div;      // Half-period counter of the serial clock
		logic [2:0]            bitc;     // Bit within byte
		logic [5:0]            bytec;    // Byte within frame
		logic [7:0]            rx;       // Receive shifter
		logic [7:0]            tx;       // Transmit shifter
		logic [7:0]            fmt;      // Captured format byte
		hub_cfg_pkg::img_t     img;      // Image, defaults until loaded
		logic                  two_byte; // Address format of the memory
		logic                  done;     // Load finished
		logic                  blank;    // Memory read blank
		logic                  fmt_ok;   // Extended format seen
		hub_cfg_pkg::apb_rsp_s rsp;
		hub_cfg_pkg::spi_out_s spi;
		hub_cfg_pkg::cfg_s     cfg;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	// ======================================================================
	// Helpers
	// Header length: instruction plus one or two address bytes
	function automatic logic [5:0] hdr_len(input logic two);
		hdr_len = two ? 6'h03 : 6'h02;
	endfunction : hdr_len

	// Outgoing byte k of the frame; data phase sends zeros
	function automatic logic [7:0] hdr_byte(input logic [5:0] k, input logic two);
		logic [7:0] cmd;
		cmd = hub_cfg_pkg::CMD_READ;
		// RULE12: ninth address bit in instruction
		if (!two)
			cmd[hub_cfg_pkg::CMD_A8_POS] = hub_cfg_pkg::START_ADDR[8];
		if (k == 6'h00)
			hdr_byte = cmd;
		else if (k == 6'h01 && two)
			hdr_byte = {7'h00, hub_cfg_pkg::START_ADDR[8]};
		else if (k == hdr_len(two) - 6'h01)
			hdr_byte = hub_cfg_pkg::START_ADDR[7:0];
		else
			hdr_byte = 8'h00;
	endfunction : hdr_byte

	// Start of pointer array i (0 is the language array), n languages
	function automatic logic [15:0] arr_base(input logic [7:0] n, input logic [2:0] i);
		arr_base = 16'(hub_cfg_pkg::OFS_LANG_ARR) + 16'(2 * n * i);
	endfunction : arr_base

	// ======================================================================
	// Next-state logic
	always_comb begin
		logic [5:0] idx;
		logic [7:0] lc;
		idx   = 6'h00;
		lc    = s_r.img[hub_cfg_pkg::OFS_LANGS];
		s_nxt = s_r;

		// Loader sequence
		case (s_r.st)
			ST_IDLE: begin
			end
			ST_START: begin
				s_nxt.img      = hub_cfg_pkg::IMG_DEFAULT;
				s_nxt.fmt      = 8'h00;
				s_nxt.done     = 1'b0;
				s_nxt.blank    = 1'b0;
				s_nxt.fmt_ok   = 1'b0;
				s_nxt.div      = 8'h00;
				s_nxt.bitc     = 3'h0;
				s_nxt.bytec    = 6'h00;
				s_nxt.tx       = hdr_byte(6'h00, s_r.two_byte);
				s_nxt.spi.sck  = 1'b0;
				s_nxt.spi.cs_n = 1'b0;
				s_nxt.st       = ST_XFER;
			end
			ST_XFER: begin
				if (s_r.div == 8'(hub_cfg_pkg::SCK_HALF_CYC - 1)) begin
					s_nxt.div = 8'h00;
					if (!s_r.spi.sck) begin
						// Rising edge: sample the memory
						s_nxt.spi.sck = 1'b1;
						s_nxt.rx      = {s_r.rx[6:0], spi_miso};
					end else begin
						// Falling edge: advance the outgoing bit
						s_nxt.spi.sck = 1'b0;
						s_nxt.tx      = {s_r.tx[6:0], 1'b0};
						s_nxt.bitc    = s_r.bitc + 3'h1;
						if (s_r.bitc == 3'h7) begin
							if (s_r.bytec >= hdr_len(s_r.two_byte)) begin
								idx = s_r.bytec - hdr_len(s_r.two_byte);
								// RULE1: format byte gates layout
								if (idx == 6'h00)
									s_nxt.fmt = s_r.rx;
								else if (s_r.fmt == hub_cfg_pkg::FMT_EXT)
									s_nxt.img[idx[4:0]] = s_r.rx;
							end
							if (s_r.bytec == hdr_len(s_r.two_byte) +
							    6'(hub_cfg_pkg::IMG_BYTES - 1)) begin
								s_nxt.spi.cs_n = 1'b1;
								s_nxt.st       = ST_FINISH;
							end else begin
								s_nxt.bytec = s_r.bytec + 6'h01;
								s_nxt.tx    = hdr_byte(s_r.bytec + 6'h01, s_r.two_byte);
							end
						end
					end
				end else begin
					s_nxt.div = s_r.div + 8'h01;
				end
			end
			ST_FINISH: begin
				// RULE11: blank memory detected
				s_nxt.blank  = (s_r.fmt == hub_cfg_pkg::FMT_BLANK);
				s_nxt.fmt_ok = (s_r.fmt == hub_cfg_pkg::FMT_EXT);
				s_nxt.done   = 1'b1;
				s_nxt.st     = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		s_nxt.spi.mosi = s_nxt.tx[7];

		// APB: answer one cycle into the access phase, capture read data at that edge
		s_nxt.rsp.pready  = apb_req.psel && apb_req.penable && !s_r.rsp.pready;
		s_nxt.rsp.pslverr = 1'b0;
		if (apb_req.psel && apb_req.penable && !s_r.rsp.pready) begin
			case (apb_req.paddr)
				hub_cfg_pkg::REG_STATUS:
					s_nxt.rsp.prdata = {28'h0000000, (s_r.st != ST_IDLE), s_r.fmt_ok,
					                    s_r.blank, s_r.done};
				hub_cfg_pkg::REG_CTRL:
					s_nxt.rsp.prdata = {31'h00000000, s_r.two_byte};
				hub_cfg_pkg::REG_ID:
					s_nxt.rsp.prdata = {s_r.cfg.product_id, s_r.cfg.vendor_id};
				hub_cfg_pkg::REG_DEV:
					s_nxt.rsp.prdata = {8'h00, s_r.cfg.power_good_delay,
					                    s_r.cfg.enabled_port_oc_filter_ms,
					                    s_r.cfg.disabled_port_oc_filter_ms,
					                    s_r.cfg.device_id_hi};
				hub_cfg_pkg::REG_POWER:
					s_nxt.rsp.prdata = {8'h00, lc, s_r.cfg.controller_current_draw,
					                    s_r.cfg.upstream_current_demand};
				// RULE10: language array and first pointer array
				hub_cfg_pkg::REG_TABLE:
					s_nxt.rsp.prdata = {arr_base(lc, 3'h1), arr_base(lc, 3'h0)};
				default: begin
					s_nxt.rsp.prdata  = 32'h00000000;
					s_nxt.rsp.pslverr = 1'b1;
				end
			endcase
		end
		// Write takes effect at the edge where pready is sampled high
		if (apb_req.psel && apb_req.penable && s_r.rsp.pready && apb_req.pwrite &&
		    apb_req.paddr == hub_cfg_pkg::REG_CTRL) begin
			s_nxt.two_byte = apb_req.pwdata[hub_cfg_pkg::CTRL_TWO_POS];
			// Reload only when idle, so a running frame is never restarted
			if (apb_req.pwdata[hub_cfg_pkg::CTRL_RLD_POS] && s_r.st == ST_IDLE)
				s_nxt.st = ST_START;
		end

		// Descriptor values, registered so the outputs come from flops
		// RULE2: identifier bytes, byte 5 unused
		s_nxt.cfg.vendor_id    = {s_r.img[hub_cfg_pkg::OFS_VID_HI],
		                          s_r.img[hub_cfg_pkg::OFS_VID_LO]};
		s_nxt.cfg.product_id   = {s_r.img[hub_cfg_pkg::OFS_PID_HI],
		                          s_r.img[hub_cfg_pkg::OFS_PID_LO]};
		s_nxt.cfg.device_id_hi = s_r.img[hub_cfg_pkg::OFS_DID_HI];
		// RULE3: filter time nibbles
		s_nxt.cfg.enabled_port_oc_filter_ms  =
			s_r.img[hub_cfg_pkg::OFS_OC][hub_cfg_pkg::OC_EN_POS +: 4];
		s_nxt.cfg.disabled_port_oc_filter_ms =
			s_r.img[hub_cfg_pkg::OFS_OC][hub_cfg_pkg::OC_DIS_POS +: 4];
		// RULE4: full-speed demand
		// RULE5: high-speed demand
		s_nxt.cfg.upstream_current_demand = high_speed ?
			s_r.img[hub_cfg_pkg::OFS_MP_HS] : s_r.img[hub_cfg_pkg::OFS_MP_FS];
		// RULE7: bus-powered current
		// RULE8: self-powered current
		if (self_powered)
			s_nxt.cfg.controller_current_draw = high_speed ?
				s_r.img[hub_cfg_pkg::OFS_HC_HS_SP] : s_r.img[hub_cfg_pkg::OFS_HC_FS_SP];
		else
			s_nxt.cfg.controller_current_draw = high_speed ?
				s_r.img[hub_cfg_pkg::OFS_HC_HS_BP] : s_r.img[hub_cfg_pkg::OFS_HC_FS_BP];
		// RULE9: power-good delay
		s_nxt.cfg.power_good_delay = s_r.img[hub_cfg_pkg::OFS_PWR_ON];
		// RULE13: hub answers only after the load
		s_nxt.cfg.hub_ready    = s_r.done && !s_r.blank && s_r.st == ST_IDLE;
		// RULE11: vendor class for programming
		s_nxt.cfg.vendor_class = s_r.done && s_r.blank && s_r.st == ST_IDLE;
	end

	// ======================================================================
	// State register; load starts straight after reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_r          <= '0;
			s_r.st       <= ST_START;
			s_r.img      <= hub_cfg_pkg::IMG_DEFAULT;
			s_r.two_byte <= ADDR_TWO_BYTE;
			s_r.spi.cs_n <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ======================================================================
	// Outputs
	assign apb_rsp = s_r.rsp;
	assign spi_out = s_r.spi;
	assign cfg     = s_r.cfg;
endmodule : hub_eeprom_extended_config_load
`default_nettype wire

// File: hub_cfg_properties.sv
`default_nettype none
// ==========================================================
// Port-level checks on the configuration loader
module hub_cfg_checker (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  rstn,
	input wire logic                  ce,
	// Register bus
	input wire hub_cfg_pkg::apb_req_s apb_req,
	input wire hub_cfg_pkg::apb_rsp_s apb_rsp,
	// Serial memory and loaded values
	input wire hub_cfg_pkg::spi_out_s spi_out,
	input wire hub_cfg_pkg::cfg_s     cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Serial link
	AST_SCK_IDLE: assert property (spi_out.cs_n |-> !spi_out.sck)
		else $error("serial clock moves while deselected");
	AST_SCK_HALF: assert property ($rose(spi_out.sck) |-> spi_out.sck [*8])
		else $error("serial clock high phase too short");
	// Data out may only move while the clock is low
	AST_MOSI_HOLD: assert property (spi_out.sck && $past(spi_out.sck) |-> $stable(spi_out.mosi))
		else $error("serial data moved in high phase");
	// ==========================================================
	// Register bus
	AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready longer than one cycle");
	AST_READY_TIME: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready && ce |=> apb_rsp.pready)
		else $error("ready not one cycle into access");
	AST_UNMAPPED: assert property (apb_rsp.pready && apb_req.paddr > 8'h14 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
		else $error("unmapped access not refused");
	// ==========================================================
	// Load order and role
	AST_FRAME_DONE: assert property ($rose(spi_out.cs_n) |-> ##[1:6] (cfg.hub_ready || cfg.vendor_class))
		else $error("no role shortly after frame end");
	// Hub is hidden three cycles after a frame starts
	AST_LOAD_HIDES: assert property ($fell(spi_out.cs_n) |-> ##3 !cfg.hub_ready)
		else $error("hub ready during load");
	AST_ONE_ROLE: assert property (!(cfg.hub_ready && cfg.vendor_class))
		else $error("hub and vendor class together");
endmodule : hub_cfg_checker
bind hub_eeprom_extended_config_load hub_cfg_checker u_chk (.core_clk(core_clk), .rstn(rstn),
	.ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .spi_out(spi_out), .cfg(cfg));
`default_nettype wire

// File: hub_eeprom_model.sv
`default_nettype none
// ==========================================================
// Serial memory holding the configuration image
module hub_eeprom_model (
	// Serial link
	input  wire hub_cfg_pkg::spi_out_s spi_out,
	output var  logic                  spi_miso,
	// Content and address format
	input  wire hub_cfg_pkg::img_t     img,
	input  wire logic                  two_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	int bits; // Rising clocks in this frame
	int idx;  // Data bit now due
	initial spi_miso = 1'b0;
	// New frame
	always @(negedge spi_out.cs_n) bits = 0;
	// Released line shows no stale value
	always @(posedge spi_out.cs_n) spi_miso = ~spi_miso;
	always @(posedge spi_out.sck) if (!spi_out.cs_n) bits++;
	// byte 0 sent first, MSB first
	always @(negedge spi_out.sck) if (!spi_out.cs_n) begin
		idx = bits - (two_byte ? 24 : 16);
		if (idx >= 0 && idx < 192)
			spi_miso = img[idx / 8][7 - idx % 8];
		else
			spi_miso = ~spi_miso;
	end
endmodule : hub_eeprom_model
`default_nettype wire

// File: tb_hub_eeprom_extended_config_load.sv
`default_nettype none
// ==========================================================
// Load, reload and refusal scenarios
module tb_hub_eeprom_extended_config_load;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  core_clk, rstn, ce, spi_miso, high_speed, self_powered, two;
	hub_cfg_pkg::apb_req_s apb_req;
	hub_cfg_pkg::apb_rsp_s apb_rsp;
	hub_cfg_pkg::spi_out_s spi_out;
	hub_cfg_pkg::cfg_s     cfg;
	hub_cfg_pkg::img_t     img;
	int                    err_total, compares, cyc;
	logic [31:0]           r;
	logic                  er;
	hub_eeprom_extended_config_load dut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .spi_out(spi_out), .spi_miso(spi_miso),
		.high_speed(high_speed), .self_powered(self_powered), .cfg(cfg));
	hub_eeprom_model mem (.spi_out(spi_out), .spi_miso(spi_miso), .img(img), .two_byte(two));
	always #10 core_clk = ~core_clk;
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		// No cycle limit here: only the hang guard ends a wait
		do begin
			@(posedge core_clk);
		end while (apb_rsp.pready !== 1'b1);
		r = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
		// Idle edge, so a following setup never reassigns the bus in this step
		@(posedge core_clk);
	endtask : apb
	// Wait for load end, then compare every speed and power mode
	task automatic run_checks;
		hub_cfg_pkg::img_t e;
		int n;
		logic [15:0] base;
		n = 0;
		base = 16'(hub_cfg_pkg::OFS_LANG_ARR);
		do begin
			apb(1'b0, hub_cfg_pkg::REG_STATUS, 32'h0);
			n++;
		end while (r[0] !== 1'b1 && n < 4000);
		e = (img[0] == 8'hD4) ? img : hub_cfg_pkg::IMG_DEFAULT;
		chk("status", r[3:0], {1'b0, img[0] == 8'hD4, img[0] == 8'hFF, 1'b1});
		for (int k = 0; k < 4; k++) begin
			high_speed <= k[0];
			self_powered <= k[1];
			repeat (2) @(posedge core_clk);
			chk("role", {cfg.vendor_class, cfg.hub_ready}, {img[0] == 8'hFF, img[0] != 8'hFF});
			chk("ids", {cfg.vendor_id, cfg.product_id}, {e[2], e[1], e[4], e[3]});
			chk("dev id", cfg.device_id_hi, e[6]);
			chk("oc", {cfg.enabled_port_oc_filter_ms, cfg.disabled_port_oc_filter_ms}, e[7]);
			chk("demand", cfg.upstream_current_demand, k[0] ? e[9] : e[8]);
			chk("contr", cfg.controller_current_draw, e[12 + k[0] + 2 * k[1]]);
			chk("pgood", cfg.power_good_delay, e[16]);
		end
		apb(1'b0, hub_cfg_pkg::REG_ID, 32'h0);
		chk("id reg", r, {e[4], e[3], e[2], e[1]});
		apb(1'b0, hub_cfg_pkg::REG_DEV, 32'h0);
		chk("dev reg", r, {8'h00, e[16], e[7], e[6]});
		apb(1'b0, hub_cfg_pkg::REG_POWER, 32'h0);
		chk("power reg", r, {8'h00, e[20], e[15], e[9]});
		apb(1'b0, hub_cfg_pkg::REG_TABLE, 32'h0);
		chk("table reg", r, {base + 16'(2 * e[20]), base});
	endtask : run_checks
	// Start a new load with the chosen address format
	task automatic reload(input logic tb);
		two = tb;
		apb(1'b1, hub_cfg_pkg::REG_CTRL, {30'h0, 1'b1, tb});
		apb(1'b0, hub_cfg_pkg::REG_CTRL, 32'h0);
		chk("ctrl", r, {31'h0, tb});
	endtask : reload
	task automatic report_and_stop;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// Main sequence
	initial begin
		core_clk = 1'b0;
		rstn = 1'b0;
		ce = 1'b1;
		high_speed = 1'b0;
		self_powered = 1'b0;
		two = 1'b1;
		apb_req = '0;
		r = $urandom(32'hE7F6BF65);
		for (int i = 1; i < 24; i++) img[i] = 8'($urandom);
		img[0] = 8'hD4;
		{img[10], img[11]} = 16'h0000;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		ce <= 1'b0;
		repeat (3) @(posedge core_clk);
		ce <= 1'b1;
		run_checks();
		// Other format code in one-byte mode keeps defaults
		img[0] = 8'hD2;
		reload(1'b0);
		run_checks();
		// Extended format read through one-byte addressing
		img[0] = 8'hD4;
		reload(1'b0);
		run_checks();
		// Blank memory
		img = '1;
		reload(1'b1);
		run_checks();
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", er, 32'h1);
		chk("unmapped data", r, 32'h0);
		report_and_stop();
	end
endmodule : tb_hub_eeprom_extended_config_load
`default_nettype wire
